//--- design/caf_consts.svh
// Constants of the CAN acceptance filter: register map, reset values, fields.
// Assumes inclusion by bare name from the package, the filter top and the test bench.
`ifndef CAF_CONSTS_SVH
`define CAF_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define CAF_ADDR_W 6
`define CAF_OFS_CODE0 6'h00
`define CAF_OFS_IGN0 6'h10
`define CAF_OFS_CTRL 6'h20
`define CAF_OFS_STAT 6'h24
`define CAF_OFS_NPASS 6'h28
`define CAF_OFS_NDROP 6'h2C

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define CAF_CTRL_EN_BIT 0
`define CAF_STAT_LAST_BIT 0
`define CAF_STAT_SEEN_BIT 1
`define CAF_RST_CODE 8'h00
`define CAF_RST_IGN 8'hFF
`define CAF_RST_CTRL_EN 1'b1
`define CAF_STD_NIBBLE_CARE 32'hFFF0_FFFF
`define CAF_EXT_CARE 32'hFFFF_FFFC

`endif

//--- design/caf_pkg.sv
// Types shared by the CAN acceptance filter modules.
// Assumes caf_consts.svh sits beside it in the include path.
`include "caf_consts.svh"

package caf_pkg;
   typedef logic [7:0] caf_byte_t;
   typedef logic [31:0] caf_word_t;
   typedef logic [`CAF_ADDR_W-1:0] caf_addr_t;
   typedef enum logic {CAF_BUS_IDLE, CAF_BUS_ACK} caf_bus_state_t;
endpackage : caf_pkg

//--- design/caf_match_if.sv
// Carrier between the filter top and its bitwise comparator.
// Assumes one clock domain; the signals are purely combinational.
interface caf_match_if;
   import caf_pkg::*;
   caf_word_t pattern;
   caf_word_t care;
   caf_word_t code;
   caf_word_t ignore;
   logic match;
   modport filt (output pattern, output care, output code, output ignore, input match);
   modport cmp (input pattern, input care, input code, input ignore, output match);
endinterface : caf_match_if

//--- design/caf_match.sv
// Bitwise comparator of the CAN acceptance filter.
// Assumes pattern and code are aligned with bit 31 as the earliest frame bit.
module caf_match (
   caf_match_if.cmp m
);
   import caf_pkg::*;

   caf_word_t miss;

   // ---------------------------------------------------------------------------
   // Per-bit compare
   // ---------------------------------------------------------------------------
   for (genvar i = 0; i < 32; i++) begin : g_bit
      // Position takes part only when mapped and not ignored
      assign miss[i] = m.care[i] & ~m.ignore[i] & (m.pattern[i] ^ m.code[i]);
   end

   assign m.match = ~|miss;
endmodule // caf_match

//--- design/caf_filter.sv
// Top of the CAN acceptance filter: Avalon-MM registers and frame decision.
// Assumes frames arrive already decoded, one per valid cycle, on mclk_i.
`include "caf_consts.svh"

module caf_filter #(
   parameter int ID_W = 29,
   parameter int CNT_W = 16
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire caf_pkg::caf_addr_t avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire caf_pkg::caf_word_t avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output caf_pkg::caf_word_t avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic frm_valid_i,
   output logic frm_ready_o,
   input wire logic frm_ext_i,
   input wire logic [ID_W-1:0] frm_id_i,
   input wire logic frm_rtr_i,
   input wire caf_pkg::caf_byte_t frm_data0_i,
   input wire caf_pkg::caf_byte_t frm_data1_i,
   output logic pass_valid_o,
   output logic pass_ext_o,
   output logic [ID_W-1:0] pass_id_o,
   output logic pass_rtr_o,
   output caf_pkg::caf_byte_t pass_data0_o,
   output caf_pkg::caf_byte_t pass_data1_o,
   output logic drop_o
);
   import caf_pkg::*;

   // ---------------------------------------------------------------------------
   // Elaboration checks
   // ---------------------------------------------------------------------------
   if (ID_W != 29) begin : g_bad_id
      $error("caf_filter: ID_W must be 29");
   end
   if (CNT_W < 1 || CNT_W > 32) begin : g_bad_cnt
      $error("caf_filter: CNT_W must be 1 to 32");
   end

   // ---------------------------------------------------------------------------
   // Reset release
   // ---------------------------------------------------------------------------
   logic [1:0] rst_sync_q;
   logic rst_q;

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_q = rst_sync_q[1];

   // ---------------------------------------------------------------------------
   // Bus slave: one wait state on every access
   // ---------------------------------------------------------------------------
   caf_bus_state_t bus_q;
   logic bus_req;
   logic bus_take;
   logic wr_take;
   logic rd_first;
   logic [3:0] idx;
   logic in_bytes;

   assign bus_req = avs_read_i | avs_write_i;
   assign avs_waitrequest_o = bus_req & (bus_q != CAF_BUS_ACK);
   assign bus_take = bus_req & (bus_q == CAF_BUS_ACK);
   assign wr_take = bus_take & avs_write_i;
   assign rd_first = avs_read_i & (bus_q == CAF_BUS_IDLE);
   assign idx = avs_address_i[5:2];
   // Byte registers share the low lane; offsets 0x00..0x1C
   assign in_bytes = (avs_address_i[1:0] == 2'b00) && (avs_address_i < `CAF_OFS_CTRL);

   always_ff @(posedge mclk_i or negedge rst_q) begin
      if (!rst_q) begin
         bus_q <= CAF_BUS_IDLE;
      end else begin
         case (bus_q)
            CAF_BUS_IDLE: begin
               if (bus_req) begin
                  bus_q <= CAF_BUS_ACK;
               end
            end
            CAF_BUS_ACK: begin
               bus_q <= CAF_BUS_IDLE;
            end
            default: begin
               bus_q <= CAF_BUS_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------------------
   // Filter registers
   // ---------------------------------------------------------------------------
   caf_byte_t code_q [4];
   caf_byte_t ign_q [4];
   logic en_q;

   for (genvar b = 0; b < 4; b++) begin : g_regs
      always_ff @(posedge mclk_i or negedge rst_q) begin
         if (!rst_q) begin
            code_q[b] <= `CAF_RST_CODE;
            ign_q[b] <= `CAF_RST_IGN;
         end else if (wr_take && in_bytes && avs_byteenable_i[0]) begin
            if (idx == 4'(b)) begin
               code_q[b] <= avs_writedata_i[7:0];
            end
            if (idx == 4'(b + 4)) begin
               ign_q[b] <= avs_writedata_i[7:0];
            end
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rst_q) begin
      if (!rst_q) begin
         en_q <= `CAF_RST_CTRL_EN;
      end else if (wr_take && avs_address_i == `CAF_OFS_CTRL && avs_byteenable_i[0]) begin
         en_q <= avs_writedata_i[`CAF_CTRL_EN_BIT];
      end
   end

   caf_word_t code_all;
   caf_word_t ign_all;
   assign code_all = {code_q[0], code_q[1], code_q[2], code_q[3]};
   assign ign_all = {ign_q[0], ign_q[1], ign_q[2], ign_q[3]};

   // ---------------------------------------------------------------------------
   // Frame mapping and compare
   // ---------------------------------------------------------------------------
   caf_match_if mif ();
   logic frm_take;
   logic accept;

   assign frm_ready_o = rst_q;
   assign frm_take = frm_valid_i & frm_ready_o;

   // Unused pattern positions are zero and masked out by care
   assign mif.pattern = frm_ext_i ? {frm_id_i, frm_rtr_i, 2'b00} :
      {frm_id_i[28:21], frm_id_i[20:18], frm_rtr_i, 4'h0, frm_data0_i, frm_data1_i};
   assign mif.care = frm_ext_i ? `CAF_EXT_CARE : `CAF_STD_NIBBLE_CARE;
   assign mif.code = code_all;
   assign mif.ignore = ign_all;

   caf_match u_match (
      .m(mif)
   );

   // Disabled filter lets everything through
   assign accept = mif.match | ~en_q;

   // ---------------------------------------------------------------------------
   // Decision outputs
   // ---------------------------------------------------------------------------
   always_ff @(posedge mclk_i or negedge rst_q) begin
      if (!rst_q) begin
         pass_valid_o <= 1'b0;
         drop_o <= 1'b0;
      end else begin
         pass_valid_o <= frm_take & accept;
         drop_o <= frm_take & ~accept;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_q) begin
      if (!rst_q) begin
         pass_ext_o <= 1'b0;
         pass_id_o <= '0;
         pass_rtr_o <= 1'b0;
         pass_data0_o <= 8'h00;
         pass_data1_o <= 8'h00;
      end else if (frm_take && accept) begin
         pass_ext_o <= frm_ext_i;
         pass_id_o <= frm_id_i;
         pass_rtr_o <= frm_rtr_i;
         pass_data0_o <= frm_data0_i;
         pass_data1_o <= frm_data1_i;
      end
   end

   // ---------------------------------------------------------------------------
   // Status and counters
   // ---------------------------------------------------------------------------
   logic last_q;
   logic seen_q;
   logic [CNT_W-1:0] npass_q;
   logic [CNT_W-1:0] ndrop_q;
   logic clr_pass;
   logic clr_drop;

   assign clr_pass = wr_take && avs_address_i == `CAF_OFS_NPASS && |avs_byteenable_i;
   assign clr_drop = wr_take && avs_address_i == `CAF_OFS_NDROP && |avs_byteenable_i;

   always_ff @(posedge mclk_i or negedge rst_q) begin
      if (!rst_q) begin
         last_q <= 1'b0;
         seen_q <= 1'b0;
      end else if (frm_take) begin
         last_q <= accept;
         seen_q <= 1'b1;
      end
   end

   // Event in the clear cycle still counts
   always_ff @(posedge mclk_i or negedge rst_q) begin
      if (!rst_q) begin
         npass_q <= '0;
      end else if (clr_pass) begin
         npass_q <= (frm_take && accept) ? CNT_W'(1) : '0;
      end else if (frm_take && accept) begin
         npass_q <= npass_q + CNT_W'(1);
      end
   end

   always_ff @(posedge mclk_i or negedge rst_q) begin
      if (!rst_q) begin
         ndrop_q <= '0;
      end else if (clr_drop) begin
         ndrop_q <= (frm_take && !accept) ? CNT_W'(1) : '0;
      end else if (frm_take && !accept) begin
         ndrop_q <= ndrop_q + CNT_W'(1);
      end
   end

   // ---------------------------------------------------------------------------
   // Read data
   // ---------------------------------------------------------------------------
   caf_word_t rd_d;

   always_comb begin
      rd_d = 32'h0000_0000;
      if (in_bytes) begin
         rd_d[7:0] = idx[2] ? ign_q[idx[1:0]] : code_q[idx[1:0]];
      end else begin
         case (avs_address_i)
            `CAF_OFS_CTRL: rd_d[`CAF_CTRL_EN_BIT] = en_q;
            `CAF_OFS_STAT: begin
               rd_d[`CAF_STAT_LAST_BIT] = last_q;
               rd_d[`CAF_STAT_SEEN_BIT] = seen_q;
            end
            `CAF_OFS_NPASS: rd_d[CNT_W-1:0] = npass_q;
            `CAF_OFS_NDROP: rd_d[CNT_W-1:0] = ndrop_q;
            default: rd_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge mclk_i or negedge rst_q) begin
      if (!rst_q) begin
         avs_readdata_o <= 32'h0000_0000;
      end else if (rd_first) begin
         avs_readdata_o <= rd_d;
      end
   end

   // ---------------------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------------------
   logic std_take;
   logic ext_take;
   assign std_take = frm_take & ~frm_ext_i & en_q;
   assign ext_take = frm_take & frm_ext_i & en_q;

   a_code_read_back: assert property (@(posedge mclk_i) disable iff (!rst_q)
      bus_take && avs_read_i && avs_address_i == `CAF_OFS_CODE0
      |-> avs_readdata_o == {24'h00_0000, code_q[0]})
      else $error("code byte 0 read back wrong");

   a_cleared_bit_cmp: assert property (@(posedge mclk_i) disable iff (!rst_q)
      std_take && !ign_q[0][7] && (code_q[0][7] != frm_id_i[28]) |=> drop_o)
      else $error("compared bit mismatch not dropped");

   a_pass_xor_drop: assert property (@(posedge mclk_i) disable iff (!rst_q)
      frm_take |=> (pass_valid_o != drop_o))
      else $error("frame neither or both passed and dropped");

   a_std_id_high: assert property (@(posedge mclk_i) disable iff (!rst_q)
      std_take && ign_q[0] == 8'h00 && ign_all[23:0] == 24'hFF_FFFF
      |=> (pass_valid_o == ($past(frm_id_i[28:21]) == $past(code_q[0]))))
      else $error("standard byte 0 compare wrong");

   a_std_low_nibble: assert property (@(posedge mclk_i) disable iff (!rst_q)
      std_take && ign_q[1] == 8'h0F && ign_q[0] == 8'hFF && ign_all[15:0] == 16'hFFFF
      && {frm_id_i[20:18], frm_rtr_i} == code_q[1][7:4] |=> pass_valid_o)
      else $error("standard byte 1 nibble compare wrong");

   a_std_data_byte: assert property (@(posedge mclk_i) disable iff (!rst_q)
      std_take && ign_q[2] == 8'h00 && frm_data0_i != code_q[2] |=> drop_o)
      else $error("standard data byte 0 mismatch passed");

   a_ext_full_id: assert property (@(posedge mclk_i) disable iff (!rst_q)
      ext_take && ign_all[31:2] == 30'h0 && {frm_id_i, frm_rtr_i} == code_all[31:2]
      |=> pass_valid_o && !drop_o)
      else $error("extended exact match not passed");

   a_rtr_ignored: assert property (@(posedge mclk_i) disable iff (!rst_q)
      ext_take && ign_all[31:3] == 29'h0 && frm_id_i == code_all[31:3]
      && ign_all[2] |=> pass_valid_o)
      else $error("ignored RTR blocked frame");

   a_all_ignored: assert property (@(posedge mclk_i) disable iff (!rst_q)
      frm_take && ign_all == 32'hFFFF_FFFF |=> pass_valid_o && !drop_o)
      else $error("fully ignored pattern dropped frame");

   a_wait_one_cycle: assert property (@(posedge mclk_i) disable iff (!rst_q)
      $rose(bus_req) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
      else $error("bus answer not after one wait state");

   a_upper_lanes_zero: assert property (@(posedge mclk_i) disable iff (!rst_q)
      bus_take && avs_read_i && in_bytes |-> avs_readdata_o[31:8] == 24'h00_0000)
      else $error("byte register read with upper lanes set");

   a_pass_fields: assert property (@(posedge mclk_i) disable iff (!rst_q)
      frm_take && accept |=> pass_id_o == $past(frm_id_i) && pass_data0_o == $past(frm_data0_i))
      else $error("accepted frame fields not forwarded");

   a_pass_count: assert property (@(posedge mclk_i) disable iff (!rst_q)
      frm_take && accept && !clr_pass |=> npass_q == $past(npass_q) + CNT_W'(1))
      else $error("pass counter did not advance");

   a_drop_count: assert property (@(posedge mclk_i) disable iff (!rst_q)
      frm_take && !accept && !clr_drop |=> ndrop_q == $past(ndrop_q) + CNT_W'(1))
      else $error("drop counter did not advance");

   a_disabled_pass: assert property (@(posedge mclk_i) disable iff (!rst_q)
      frm_take && !en_q |=> pass_valid_o && !drop_o)
      else $error("disabled filter dropped frame");

   c_std_pass: cover property (@(posedge mclk_i) disable iff (!rst_q)
      std_take ##1 pass_valid_o);
   c_ext_drop: cover property (@(posedge mclk_i) disable iff (!rst_q)
      ext_take ##1 drop_o);
   c_reg_write: cover property (@(posedge mclk_i) disable iff (!rst_q)
      wr_take && in_bytes);
   c_back_to_back: cover property (@(posedge mclk_i) disable iff (!rst_q)
      frm_take ##1 frm_take);
   c_rtr_masked: cover property (@(posedge mclk_i) disable iff (!rst_q)
      ext_take && ign_all[2] ##1 pass_valid_o);
endmodule // caf_filter

//--- bench/caf_frame_src.sv
// Frame source standing in for the CAN receive path of the filter.
// Assumes one clock; frames are queued by the bench and leave one per cycle.
module caf_frame_src (
   input wire logic mclk_i,
   input wire logic frm_ready_i,
   output logic frm_valid_o,
   output logic frm_ext_o,
   output logic [28:0] frm_id_o,
   output logic frm_rtr_o,
   output caf_pkg::caf_byte_t frm_data0_o,
   output caf_pkg::caf_byte_t frm_data1_o
);
   timeunit 1ns;
   timeprecision 1ps;
   import caf_pkg::*;
   logic [46:0] q[$];

   task automatic push(input logic [46:0] f);
      q.push_back(f);
   endtask

   initial begin
      frm_valid_o = 1'b0;
      {frm_ext_o, frm_id_o, frm_rtr_o, frm_data0_o, frm_data1_o} = '0;
   end

   // Fields toggle between frames so stale values never look valid
   always @(posedge mclk_i) begin
      if (frm_ready_i === 1'b1 && q.size() != 0) begin
         {frm_ext_o, frm_id_o, frm_rtr_o, frm_data0_o, frm_data1_o} <= q.pop_front();
         frm_valid_o <= 1'b1;
      end else begin
         {frm_ext_o, frm_id_o, frm_rtr_o, frm_data0_o, frm_data1_o} <=
            ~{frm_ext_o, frm_id_o, frm_rtr_o, frm_data0_o, frm_data1_o};
         frm_valid_o <= 1'b0;
      end
   end
endmodule // caf_frame_src

//--- bench/caf_filter_test.sv
// Self-checking bench of the acceptance filter: register bus and frame decisions.
// Assumes caf_frame_src as the receive path and a 100 MHz clock.
`include "caf_consts.svh"

module caf_filter_test;
   timeunit 1ns;
   timeprecision 1ps;
   import caf_pkg::*;
   logic mclk_i = 1'b0;
   logic rst_n_i = 1'b0;
   caf_addr_t avs_address_i = '0;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   caf_word_t avs_writedata_i = '0;
   logic [3:0] avs_byteenable_i = 4'hF;
   caf_word_t avs_readdata_o;
   logic avs_waitrequest_o, frm_valid_i, frm_ready_o, frm_ext_i, frm_rtr_i;
   logic [28:0] frm_id_i, pass_id_o;
   caf_byte_t frm_data0_i, frm_data1_i, pass_data0_o, pass_data1_o;
   logic pass_valid_o, pass_ext_o, pass_rtr_o, drop_o;
   caf_byte_t code_sh[4], ign_sh[4];
   logic en_sh = 1'b1;
   logic [47:0] exp_q[$];
   int miscompares = 0;
   int num_checks = 0;
   int npass = 0;
   int ndrop = 0;

   always #5 mclk_i = ~mclk_i;

   caf_filter i_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
      .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o), .frm_valid_i(frm_valid_i),
      .frm_ready_o(frm_ready_o), .frm_ext_i(frm_ext_i), .frm_id_i(frm_id_i),
      .frm_rtr_i(frm_rtr_i), .frm_data0_i(frm_data0_i), .frm_data1_i(frm_data1_i),
      .pass_valid_o(pass_valid_o), .pass_ext_o(pass_ext_o), .pass_id_o(pass_id_o),
      .pass_rtr_o(pass_rtr_o), .pass_data0_o(pass_data0_o), .pass_data1_o(pass_data1_o),
      .drop_o(drop_o));

   caf_frame_src i_src (.mclk_i(mclk_i), .frm_ready_i(frm_ready_o), .frm_valid_o(frm_valid_i),
      .frm_ext_o(frm_ext_i), .frm_id_o(frm_id_i), .frm_rtr_o(frm_rtr_i),
      .frm_data0_o(frm_data0_i), .frm_data1_o(frm_data1_i));

   // ---------------------------------------------------------------------
   // Reporting and comparison
   // ---------------------------------------------------------------------
   task automatic fail(input string msg);
      miscompares++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
   endtask

   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk_word(input caf_word_t got, input caf_word_t exp);
      num_checks++;
      if (got !== exp) fail($sformatf("register read %h, expected %h", got, exp));
   endtask

   task automatic chk_frame(input logic [47:0] e);
      num_checks++;
      if ({pass_valid_o, drop_o} !== {e[47], !e[47]}) fail("wrong pass or drop decision");
      else if (e[47] && {pass_ext_o, pass_id_o, pass_rtr_o, pass_data0_o, pass_data1_o}
               !== e[46:0]) fail("accepted frame fields differ");
   endtask

   // ---------------------------------------------------------------------
   // Avalon-MM master; waitrequest is sampled at each rising edge
   // ---------------------------------------------------------------------
   task automatic bus(input logic is_wr, input caf_addr_t a, input caf_word_t d,
                      output caf_word_t q);
      int n;
      n = 0;
      // Idle edge first, so a release and a new request never share a step
      @(posedge mclk_i);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_read_i <= !is_wr;
      avs_write_i <= is_wr;
      do begin
         @(posedge mclk_i);
         n++;
      end while (avs_waitrequest_o !== 1'b0 && n < 50);
      if (avs_waitrequest_o !== 1'b0) fail("bus request never answered");
      q = avs_readdata_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
   endtask

   task automatic wr(input caf_addr_t a, input caf_word_t d);
      caf_word_t q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rd_chk(input caf_addr_t a, input caf_word_t exp);
      caf_word_t q;
      bus(1'b0, a, 32'h0000_0000, q);
      chk_word(q, exp);
   endtask

   task automatic cfg(input logic [31:0] c, input logic [31:0] g);
      for (int i = 0; i < 4; i++) begin
         code_sh[i] = c[31-8*i -: 8];
         ign_sh[i] = g[31-8*i -: 8];
         wr(caf_addr_t'(`CAF_OFS_CODE0 + 4*i), {24'h00_0000, code_sh[i]});
         wr(caf_addr_t'(`CAF_OFS_IGN0 + 4*i), {24'h00_0000, ign_sh[i]});
      end
   endtask

   // ---------------------------------------------------------------------
   // Frames: expectation from the bit mapping, then queued at the source
   // ---------------------------------------------------------------------
   task automatic frm(input logic ext, input logic [28:0] id, input logic rtr,
                      input caf_byte_t d0, input caf_byte_t d1);
      caf_word_t pat, care;
      logic e;
      pat = ext ? {id, rtr, 2'b00} : {id[28:18], rtr, 4'h0, d0, d1};
      care = ext ? 32'hFFFF_FFFC : 32'hFFF0_FFFF;
      e = !en_sh || (((pat ^ {code_sh[0], code_sh[1], code_sh[2], code_sh[3]}) &
          ~{ign_sh[0], ign_sh[1], ign_sh[2], ign_sh[3]} & care) == 32'h0000_0000);
      if (e) npass++;
      else ndrop++;
      exp_q.push_back({e, ext, id, rtr, d0, d1});
      i_src.push({ext, id, rtr, d0, d1});
   endtask

   task automatic drain(input string name);
      int n;
      n = 0;
      while (exp_q.size() != 0 && n < 100) begin
         @(posedge mclk_i);
         n++;
      end
      @(negedge mclk_i);
      if (exp_q.size() != 0) fail("decisions missing");
      $display("test %s done", name);
   endtask

   always @(negedge mclk_i) begin
      if (pass_valid_o !== 1'b0 || drop_o !== 1'b0) begin
         if (exp_q.size() == 0) fail("decision without a frame");
         else chk_frame(exp_q.pop_front());
      end
   end

   initial begin
      #200us;
      fail("watchdog expired");
      report_and_stop();
   end

   // ---------------------------------------------------------------------
   // Test sequence
   // ---------------------------------------------------------------------
   initial begin
      for (int i = 0; i < 4; i++) begin
         code_sh[i] = 8'h00;
         ign_sh[i] = 8'hFF;
      end
      repeat (16) @(posedge mclk_i);
      chk_word({31'h0000_0000, frm_ready_o}, 32'h0000_0000);
      rst_n_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      chk_word({31'h0000_0000, frm_ready_o}, 32'h0000_0001);
      for (int i = 0; i < 4; i++) begin
         rd_chk(caf_addr_t'(`CAF_OFS_CODE0 + 4*i), 32'h0000_0000);
         rd_chk(caf_addr_t'(`CAF_OFS_IGN0 + 4*i), 32'h0000_00FF);
      end
      rd_chk(`CAF_OFS_CTRL, 32'h0000_0001);
      rd_chk(6'h30, 32'h0000_0000);
      frm(1'b0, 29'h1ABC_DEF0, 1'b1, 8'h5A, 8'hA5);
      frm(1'b1, 29'h0123_4567, 1'b0, 8'h00, 8'hFF);
      drain("reset");
      cfg(32'hA5B5_3CC3, 32'h0000_0000);
      for (int i = 0; i < 4; i++) begin
         rd_chk(caf_addr_t'(`CAF_OFS_CODE0 + 4*i), {24'h00_0000, code_sh[i]});
      end
      frm(1'b0, {8'hA5, 3'b101, 18'h2_A5A5}, 1'b1, 8'h3C, 8'hC3);
      frm(1'b0, {8'hA5, 3'b101, 18'h2_A5A5}, 1'b0, 8'h3C, 8'hC3);
      frm(1'b0, {8'hA5, 3'b100, 18'h2_A5A5}, 1'b1, 8'h3C, 8'hC3);
      frm(1'b0, {8'h25, 3'b101, 18'h2_A5A5}, 1'b1, 8'h3C, 8'hC3);
      frm(1'b0, {8'hA5, 3'b101, 18'h0_0000}, 1'b1, 8'h3D, 8'hC3);
      frm(1'b0, {8'hA5, 3'b101, 18'h0_0000}, 1'b1, 8'h3C, 8'h43);
      drain("standard");
      cfg(32'h4200_0000, 32'h38FF_FFFF);
      frm(1'b0, {8'h7A, 21'h0_0000}, 1'b0, 8'h00, 8'h00);
      frm(1'b0, {8'h52, 21'h1F_FFFF}, 1'b1, 8'hFF, 8'h12);
      frm(1'b0, {8'h43, 21'h0_0000}, 1'b0, 8'h00, 8'h00);
      frm(1'b0, {8'hC2, 21'h0_0000}, 1'b0, 8'h00, 8'h00);
      drain("example");
      cfg(32'hB4B0_C033, 32'h0001_0F04);
      frm(1'b1, {8'hB4, 8'hB0, 8'hC0, 5'b00110}, 1'b0, 8'hFF, 8'h11);
      frm(1'b1, {8'hB4, 8'hB0, 8'hC0, 5'b00110}, 1'b1, 8'h00, 8'h00);
      frm(1'b1, {8'hB4, 8'hB0, 8'hC0, 5'b00111}, 1'b0, 8'h00, 8'h00);
      frm(1'b1, {8'hB4, 8'hB1, 8'hCF, 5'b00110}, 1'b0, 8'h00, 8'h00);
      frm(1'b1, {8'h34, 8'hB0, 8'hC0, 5'b00110}, 1'b0, 8'h00, 8'h00);
      drain("extended");
      // Low code nibble of byte 1 set on purpose: it must not take part
      cfg(32'h00B5_0000, 32'hFF0F_FFFF);
      frm(1'b0, {8'h00, 3'b101, 18'h0_0000}, 1'b1, 8'h00, 8'h00);
      frm(1'b0, {8'h00, 3'b101, 18'h0_0000}, 1'b0, 8'h00, 8'h00);
      drain("nibble");
      // Code bits 1:0 set on purpose: they must not take part
      cfg(32'h1234_567B, 32'h0000_0000);
      frm(1'b1, 29'h0246_8ACF, 1'b0, 8'h00, 8'h00);
      frm(1'b1, 29'h0246_8ACF, 1'b1, 8'h00, 8'h00);
      drain("exact");
      cfg(32'h1234_567B, 32'h0000_0004);
      frm(1'b1, 29'h0246_8ACF, 1'b1, 8'h00, 8'h00);
      drain("remote");
      wr(`CAF_OFS_CTRL, 32'h0000_0000);
      en_sh = 1'b0;
      frm(1'b1, 29'h1555_5555, 1'b1, 8'h00, 8'h00);
      drain("disabled");
      rd_chk(`CAF_OFS_NPASS, 32'(npass));
      rd_chk(`CAF_OFS_NDROP, 32'(ndrop));
      rd_chk(`CAF_OFS_STAT, 32'h0000_0003);
      wr(`CAF_OFS_NPASS, 32'h0000_0000);
      rd_chk(`CAF_OFS_NPASS, 32'h0000_0000);
      $display("test counters done");
      report_and_stop();
   end
endmodule // caf_filter_test
